/* File: rtl/dto_pkg.sv */
package dto_pkg;

  // Frame geometry: 56 blocks of 85 bits, the first bit of each is overhead.
  localparam int BLOCK_BITS = 85;
  localparam int OH_BITS = 56;
  localparam logic [6:0] LAST_POS = 7'h54;
  localparam logic [5:0] LAST_IDX = 6'h37;
  localparam logic [6:0] OH_POS = 7'h00;
  localparam logic [6:0] LATE_SAMPLE_POS = 7'h01;

  // Counters start two bits before the first overhead bit after reset.
  localparam logic [6:0] RESET_POS = 7'h53;
  localparam logic [5:0] RESET_IDX = 6'h37;

  // Subframe layout of the first bit of each subframe.
  localparam logic [2:0] X_LAST_SUB = 3'h1;
  localparam logic [2:0] P_LAST_SUB = 3'h3;
  localparam logic [2:0] M_FIRST_SUB = 3'h4;

  // Subframe holding the far-end alarm code in its third C slot.
  localparam logic [2:0] ALARM_SUB = 3'h0;
  localparam logic [1:0] ALARM_CODE_SLOT = 2'h2;
  localparam logic [2:0] END_PARITY_SUB = 3'h2;
  localparam logic [2:0] BLOCK_ERR_SUB = 3'h3;
  localparam logic [2:0] PATH_LINK_SUB = 3'h4;

  // Framing patterns, F1 in bit 0 and M1 in bit 0.
  localparam logic [3:0] F_PATTERN = 4'h9;
  localparam logic [2:0] M_PATTERN = 3'h2;

  // Value sent where nothing supplies a bit.
  localparam logic IDLE_BIT = 1'h1;

  // Depth of the buffer on the maintenance link path.
  localparam int LINK_BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    OH_FSYNC,
    OH_PARITY,
    OH_END_PARITY,
    OH_ALARM_X,
    OH_ALARM_CODE,
    OH_BLOCK_ERR,
    OH_USER_LINK,
    OH_PATH_LINK,
    OH_FIXED
  } dto_oh_class_t;

endpackage

/* File: rtl/dto_stream_if.sv */
`timescale 1ns/1ps
// Valid/ready word stream between the block's own modules.
interface dto_stream_if #(parameter int W = 1) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/dto_slot_map.sv */
`timescale 1ns/1ps
// Maps an overhead index to its kind and its framing value.
module dto_slot_map (
  input logic [5:0] oh_index,
  output dto_pkg::dto_oh_class_t oh_class,
  output logic sync_value
);

  logic [2:0] sub;
  logic [2:0] blk;
  logic [1:0] cslot;

  // Index = subframe * 8 + block; odd blocks are F, even nonzero are C.
  always_comb
  begin
    sub = oh_index[5:3];
    blk = oh_index[2:0];
    cslot = 2'(blk[2:1] - 2'h1);
    sync_value = 1'h0;
    oh_class = dto_pkg::OH_FIXED;
    if (blk == 3'h0)
    begin
      if (sub <= dto_pkg::X_LAST_SUB)
        oh_class = dto_pkg::OH_ALARM_X;
      else if (sub <= dto_pkg::P_LAST_SUB)
        oh_class = dto_pkg::OH_PARITY;
      else
      begin
        oh_class = dto_pkg::OH_FSYNC;
        sync_value = dto_pkg::M_PATTERN[2'(sub - dto_pkg::M_FIRST_SUB)];
      end
    end
    else if (blk[0])
    begin
      oh_class = dto_pkg::OH_FSYNC;
      sync_value = dto_pkg::F_PATTERN[blk[2:1]];
    end
    else if (sub == dto_pkg::ALARM_SUB)
      oh_class = (cslot == dto_pkg::ALARM_CODE_SLOT)
                 ? dto_pkg::OH_ALARM_CODE
                 : dto_pkg::OH_FIXED;
    else if (sub == dto_pkg::END_PARITY_SUB)
      oh_class = dto_pkg::OH_END_PARITY;
    else if (sub == dto_pkg::BLOCK_ERR_SUB)
      oh_class = dto_pkg::OH_BLOCK_ERR;
    else if (sub == dto_pkg::PATH_LINK_SUB)
      oh_class = dto_pkg::OH_PATH_LINK;
    else
      oh_class = dto_pkg::OH_USER_LINK;
  end

endmodule

/* File: rtl/dto_buffer.sv */
`timescale 1ns/1ps
// Small FIFO; a full buffer holds its ready low so the source waits.
module dto_buffer #(
  parameter int W = 1,
  parameter int DEPTH = 2
) (
  input logic clk,
  input logic rst_n,
  dto_stream_if.snk in_s,
  dto_stream_if.src out_s
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data = mem_r[rp_r];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Pointer and fill count update; push and pop may share a cycle.
  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wp_r] = in_s.data;
      wp_nxt = bump(wp_r);
    end
    if (pop)
      rp_nxt = bump(rp_r);
    if (push && !pop)
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    else if (pop && !push)
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule

/* File: rtl/dto_tx_overhead.sv */
`timescale 1ns/1ps
module dto_tx_overhead #(
  parameter int LINK_DEPTH = dto_pkg::LINK_BUF_DEPTH
) (
  input logic clk,
  input logic rst_n,
  input logic transmit_input_clock,
  input logic method_select,
  input logic mask_fsync,
  input logic mask_parity,
  input logic path_link_from_lapd,
  input logic parity_bit,
  input logic alarm_x_bit,
  input logic alarm_code_bit,
  input logic block_error_bit,
  input logic end_parity_default_bit,
  input logic lapd_valid,
  input logic lapd_data,
  output logic lapd_ready,
  input logic overhead_serial_in,
  input logic overhead_insert_enable,
  output logic overhead_bit_clock,
  output logic overhead_frame_marker,
  output logic overhead_slot_enable,
  output logic oh_bit_valid,
  output logic oh_bit_value,
  output logic [5:0] oh_bit_index,
  output logic oh_bit_inserted
);

  // Pin synchronisers; stage one feeds only stage two.
  logic tic_s1_r, tic_s2_r, tic_s3_r;
  logic ins_s1_r, ins_s2_r;
  logic din_s1_r, din_s2_r;
  logic bit_en;

  // Frame position counters.
  logic [6:0] pos_r, pos_nxt;
  logic [5:0] idx_r, idx_nxt;

  // Per-position store of values sampled in the previous frame.
  logic [55:0] flag_r, flag_nxt;
  logic [55:0] val_r, val_nxt;

  // Registered port outputs.
  logic ohclk_r, ohclk_nxt;
  logic frame_r, frame_nxt;
  logic slot_r, slot_nxt;
  logic ovalid_r, ovalid_nxt;
  logic ovalue_r, ovalue_nxt;
  logic [5:0] oindex_r, oindex_nxt;
  logic oins_r, oins_nxt;

  // Decode of the overhead bit at the next position.
  dto_pkg::dto_oh_class_t oh_class;
  logic sync_value;
  logic oh_enter;
  logic samp_edge;
  logic insertable;
  logic ext_flag;
  logic ext_val;

  dto_stream_if #(.W(1)) lapd_in ();
  dto_stream_if #(.W(1)) lapd_out ();

  // Maintenance link bits wait here so a late slot loses no bit.
  assign lapd_in.valid = lapd_valid;
  assign lapd_in.data = lapd_data;
  assign lapd_ready = lapd_in.ready;

  dto_buffer #(
    .W(1),
    .DEPTH(LINK_DEPTH)
  ) u_link_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(lapd_in),
    .out_s(lapd_out)
  );

  dto_slot_map u_slot_map (
    .oh_index(idx_nxt),
    .oh_class(oh_class),
    .sync_value(sync_value)
  );

  // The input clock and port pins are asynchronous to clk.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tic_s1_r <= 1'h0;
      tic_s2_r <= 1'h0;
      tic_s3_r <= 1'h0;
      ins_s1_r <= 1'h0;
      ins_s2_r <= 1'h0;
      din_s1_r <= 1'h0;
      din_s2_r <= 1'h0;
    end
    else
    begin
      tic_s1_r <= transmit_input_clock;
      tic_s2_r <= tic_s1_r;
      tic_s3_r <= tic_s2_r;
      ins_s1_r <= overhead_insert_enable;
      ins_s2_r <= ins_s1_r;
      din_s1_r <= overhead_serial_in;
      din_s2_r <= din_s1_r;
    end
  end

  // One DS3 bit per rising edge of the input clock.
  assign bit_en = tic_s2_r & ~tic_s3_r;

  // Bit counter within a block, and block counter within the frame.
  always_comb
  begin
    pos_nxt = pos_r;
    idx_nxt = idx_r;
    if (bit_en)
    begin
      if (pos_r == dto_pkg::LAST_POS)
      begin
        pos_nxt = dto_pkg::OH_POS;
        idx_nxt = (idx_r == dto_pkg::LAST_IDX)
                  ? 6'h00 : 6'(idx_r + 6'h01);
      end
      else
        pos_nxt = 7'(pos_r + 7'h01);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pos_r <= dto_pkg::RESET_POS;
      idx_r <= dto_pkg::RESET_IDX;
    end
    else
    begin
      pos_r <= pos_nxt;
      idx_r <= idx_nxt;
    end
  end

  // In method one, entering an overhead bit is also the falling bit clock edge.
  assign oh_enter = bit_en & (pos_nxt == dto_pkg::OH_POS);

  // Method two samples at the end of the slot, so data had a full bit.
  assign samp_edge = method_select
                     ? (bit_en & (pos_nxt == dto_pkg::LATE_SAMPLE_POS))
                     : oh_enter;

  assign ext_flag = flag_r[idx_nxt];
  assign ext_val = val_r[idx_nxt];

  // Only these kinds accept a port value; the rest drop it.
  always_comb
  begin
    insertable = 1'h0;
    unique case (oh_class)
      dto_pkg::OH_END_PARITY,
      dto_pkg::OH_ALARM_X,
      dto_pkg::OH_ALARM_CODE,
      dto_pkg::OH_BLOCK_ERR,
      dto_pkg::OH_USER_LINK:
        insertable = 1'h1;
      dto_pkg::OH_PATH_LINK:
        insertable = ~path_link_from_lapd;
      dto_pkg::OH_FSYNC,
      dto_pkg::OH_PARITY,
      dto_pkg::OH_FIXED:
        insertable = 1'h0;
    endcase
  end

  // Capture at the sampling edge; a low enable clears the stored flag.
  always_comb
  begin
    flag_nxt = flag_r;
    val_nxt = val_r;
    if (samp_edge)
    begin
      flag_nxt[idx_nxt] = ins_s2_r & insertable;
      if (ins_s2_r && insertable)
        val_nxt[idx_nxt] = din_s2_r;
    end
  end

  // Overhead value selection; the store is read before this edge writes it.
  always_comb
  begin
    ovalid_nxt = oh_enter;
    oindex_nxt = oindex_r;
    ovalue_nxt = ovalue_r;
    oins_nxt = oins_r;
    lapd_out.ready = 1'h0;
    if (oh_enter)
    begin
      oindex_nxt = idx_nxt;
      oins_nxt = 1'h0;
      unique case (oh_class)
        dto_pkg::OH_FSYNC:
          ovalue_nxt = sync_value ^ mask_fsync;
        dto_pkg::OH_PARITY:
          ovalue_nxt = parity_bit ^ mask_parity;
        dto_pkg::OH_END_PARITY:
        begin
          ovalue_nxt = ext_flag ? ext_val : end_parity_default_bit;
          oins_nxt = ext_flag;
        end
        dto_pkg::OH_ALARM_X:
        begin
          ovalue_nxt = ext_flag ? ext_val : alarm_x_bit;
          oins_nxt = ext_flag;
        end
        dto_pkg::OH_ALARM_CODE:
        begin
          ovalue_nxt = ext_flag ? ext_val : alarm_code_bit;
          oins_nxt = ext_flag;
        end
        dto_pkg::OH_BLOCK_ERR:
        begin
          ovalue_nxt = ext_flag ? ext_val : block_error_bit;
          oins_nxt = ext_flag;
        end
        dto_pkg::OH_USER_LINK:
        begin
          ovalue_nxt = ext_flag ? ext_val : dto_pkg::IDLE_BIT;
          oins_nxt = ext_flag;
        end
        dto_pkg::OH_PATH_LINK:
        begin
          if (path_link_from_lapd)
          begin
            lapd_out.ready = 1'h1;
            ovalue_nxt = lapd_out.valid ? lapd_out.data : dto_pkg::IDLE_BIT;
          end
          else
          begin
            ovalue_nxt = ext_flag ? ext_val : dto_pkg::IDLE_BIT;
            oins_nxt = ext_flag;
          end
        end
        dto_pkg::OH_FIXED:
          ovalue_nxt = dto_pkg::IDLE_BIT;
      endcase
    end
  end

  // Port strobes change only on bit boundaries, one bit period each.
  always_comb
  begin
    ohclk_nxt = ohclk_r;
    frame_nxt = frame_r;
    slot_nxt = slot_r;
    if (bit_en)
    begin
      ohclk_nxt = ~method_select & (pos_nxt == dto_pkg::LAST_POS);
      frame_nxt = (pos_nxt == dto_pkg::LAST_POS) &
                  (idx_nxt == dto_pkg::LAST_IDX);
      slot_nxt = method_select & (pos_nxt == dto_pkg::OH_POS);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_r <= '0;
      val_r <= '0;
      ohclk_r <= 1'h0;
      frame_r <= 1'h0;
      slot_r <= 1'h0;
      ovalid_r <= 1'h0;
      ovalue_r <= 1'h0;
      oindex_r <= 6'h00;
      oins_r <= 1'h0;
    end
    else
    begin
      flag_r <= flag_nxt;
      val_r <= val_nxt;
      ohclk_r <= ohclk_nxt;
      frame_r <= frame_nxt;
      slot_r <= slot_nxt;
      ovalid_r <= ovalid_nxt;
      ovalue_r <= ovalue_nxt;
      oindex_r <= oindex_nxt;
      oins_r <= oins_nxt;
    end
  end

  // The three overhead port strobes and the four per-bit result signals.
  assign overhead_bit_clock = ohclk_r;
  assign overhead_frame_marker = frame_r;
  assign overhead_slot_enable = slot_r;
  assign oh_bit_valid = ovalid_r;
  assign oh_bit_value = ovalue_r;
  assign oh_bit_index = oindex_r;
  assign oh_bit_inserted = oins_r;

endmodule

/* File: bench/dto_tx_overhead_assertions.sv */
`timescale 1ns/1ps
// Watches the bit clock and frame marker pins and the per-bit result stream.
module dto_tx_overhead_checker (
  input logic clk,
  input logic rst_n,
  input logic method_select,
  input logic mask_fsync,
  input logic mask_parity,
  input logic parity_bit,
  input logic alarm_x_bit,
  input logic overhead_bit_clock,
  input logic overhead_frame_marker,
  input logic oh_bit_valid,
  input logic oh_bit_value,
  input logic [5:0] oh_bit_index,
  input logic oh_bit_inserted
);
  default clocking
    @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [5:0] prev_idx_r;
  logic is_x;
  logic is_p;
  logic is_m;
  // Last index seen; reset to the final one so the first bit must be zero.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prev_idx_r <= dto_pkg::LAST_IDX;
    else if (oh_bit_valid)
      prev_idx_r <= oh_bit_index;
  end
  // Block zero holds X, then parity, then sync bits by subframe.
  assign is_x = oh_bit_index[2:0] == 3'h0 && oh_bit_index[5:4] == 2'h0;
  assign is_p = oh_bit_index[2:0] == 3'h0 && oh_bit_index[5:4] == 2'h1;
  assign is_m = oh_bit_index[2:0] == 3'h0 && oh_bit_index[5];
  a_fsync_own: assert property (
    oh_bit_valid && oh_bit_index[0] |-> !oh_bit_inserted && oh_bit_value ==
    (dto_pkg::F_PATTERN[oh_bit_index[2:1]] ^ $past(mask_fsync)))
    else $error("F bit not made inside");
  a_msync_own: assert property (
    oh_bit_valid && is_m |-> !oh_bit_inserted && oh_bit_value ==
    (dto_pkg::M_PATTERN[oh_bit_index[4:3]] ^ $past(mask_fsync)))
    else $error("M bit not made inside");
  a_parity_own: assert property (
    oh_bit_valid && is_p |-> !oh_bit_inserted &&
    oh_bit_value == ($past(parity_bit) ^ $past(mask_parity)))
    else $error("P bit not made inside");
  a_refuse_fixed: assert property (
    oh_bit_valid && (oh_bit_index == 6'h02 || oh_bit_index == 6'h04)
    |-> !oh_bit_inserted)
    else $error("fixed C bit taken from port");
  a_x_default: assert property (
    oh_bit_valid && is_x && !oh_bit_inserted
    |-> oh_bit_value == $past(alarm_x_bit))
    else $error("X bit lost its inside value");
  a_clock_width: assert property (
    $rose(overhead_bit_clock)
    |-> overhead_bit_clock[*8] ##[4:12] !overhead_bit_clock)
    else $error("bit clock high time wrong");
  a_bit_after_clk: assert property (
    $fell(overhead_bit_clock) && !method_select |-> oh_bit_valid)
    else $error("bit clock fell without a bit");
  a_clk_before_bit: assert property (
    oh_bit_valid && !method_select |-> $past(overhead_bit_clock))
    else $error("bit without bit clock");
  a_marker_start: assert property (
    $fell(overhead_frame_marker) && !method_select
    |-> oh_bit_valid && oh_bit_index == 6'h00)
    else $error("marker not before bit zero");
  a_marker_in_clk: assert property (
    overhead_frame_marker && !method_select |-> overhead_bit_clock)
    else $error("marker outside bit clock");
  a_index_step: assert property (
    oh_bit_valid |-> oh_bit_index == ((prev_idx_r == dto_pkg::LAST_IDX)
    ? 6'h00 : prev_idx_r + 6'h01))
    else $error("overhead index out of order");
endmodule

bind dto_tx_overhead dto_tx_overhead_checker u_chk (
  .clk(clk), .rst_n(rst_n), .method_select(method_select),
  .mask_fsync(mask_fsync), .mask_parity(mask_parity),
  .parity_bit(parity_bit), .alarm_x_bit(alarm_x_bit),
  .overhead_bit_clock(overhead_bit_clock),
  .overhead_frame_marker(overhead_frame_marker),
  .oh_bit_valid(oh_bit_valid), .oh_bit_value(oh_bit_value),
  .oh_bit_index(oh_bit_index), .oh_bit_inserted(oh_bit_inserted)
);

/* File: bench/dto_terminal_model.sv */
`timescale 1ns/1ps
// Terminal equipment on the overhead port, inserting the bits its
// tables pick in every frame of method one, where the bit clock runs.
module dto_terminal_model (
  input logic clk,
  input logic overhead_bit_clock,
  input logic overhead_frame_marker,
  input logic [55:0] ins_mask,
  input logic [55:0] ins_value,
  output logic overhead_insert_enable,
  output logic overhead_serial_in
);
  logic seen_r = 1'h0;
  logic [5:0] idx_r = 6'h00;
  initial overhead_insert_enable = 1'h0;
  initial overhead_serial_in = 1'h0;
  // Rises are found on the system clock so marker and clock are read
  // together; data is set one clock after the rise, nearly a whole bit before the falling edge.
  always @(posedge clk)
  begin
    if (overhead_bit_clock && !seen_r)
    begin
      idx_r = overhead_frame_marker ? 6'h00 : idx_r + 6'h01;
      overhead_insert_enable <= ins_mask[idx_r];
      // An unused data line flips so a stray sample never matches.
      overhead_serial_in <= ins_mask[idx_r] ? ins_value[idx_r]
        : ~overhead_serial_in;
    end
    seen_r <= overhead_bit_clock;
  end
endmodule

/* File: bench/dto_tx_overhead_bench.sv */
`timescale 1ns/1ps
module dto_tx_overhead_bench;
  // Bits offered on the port each frame, and their values.
  localparam logic [55:0] INS_MASK = 56'h00_0004_0015_0447;
  localparam logic [55:0] INS_VALUE = 56'h00_0000_0010_0042;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic transmit_input_clock = 1'h0;
  logic method_select = 1'h0;
  logic mask_fsync = 1'h0;
  logic mask_parity = 1'h0;
  logic path_link_from_lapd = 1'h1;
  logic parity_bit = 1'h1;
  logic alarm_x_bit = 1'h1;
  logic alarm_code_bit = 1'h0;
  logic block_error_bit = 1'h0;
  logic end_parity_default_bit = 1'h1;
  logic lapd_valid = 1'h0;
  logic lapd_data = 1'h0;
  logic lapd_ready;
  logic overhead_serial_in;
  logic overhead_insert_enable;
  logic overhead_bit_clock;
  logic overhead_frame_marker;
  logic overhead_slot_enable;
  logic oh_bit_valid;
  logic oh_bit_value;
  logic [5:0] oh_bit_index;
  logic oh_bit_inserted;
  int errors = 0;
  int n_tests = 0;
  int hits = 0;
  int stray = 0;
  // Row: index, sync mask, parity mask, value, from port; two frames.
  logic [9:0] rows [25] = '{
    10'h002, 10'h012, 10'h022, 10'h030, 10'h060, 10'h082, 10'h0A2,
    10'h102, 10'h122, 10'h142, 10'h1A0, 10'h222, 10'h240, 10'h262,
    10'h2A2, 10'h00D, 10'h01C, 10'h02E, 10'h06F, 10'h08C, 10'h0AD,
    10'h10C, 10'h12D, 10'h14F, 10'h16E};

  dto_tx_overhead uut (
    .clk(clk), .rst_n(rst_n), .transmit_input_clock(transmit_input_clock),
    .method_select(method_select), .mask_fsync(mask_fsync),
    .mask_parity(mask_parity),
    .path_link_from_lapd(path_link_from_lapd),
    .parity_bit(parity_bit), .alarm_x_bit(alarm_x_bit),
    .alarm_code_bit(alarm_code_bit), .block_error_bit(block_error_bit),
    .end_parity_default_bit(end_parity_default_bit),
    .lapd_valid(lapd_valid),
    .lapd_data(lapd_data), .lapd_ready(lapd_ready),
    .overhead_serial_in(overhead_serial_in),
    .overhead_insert_enable(overhead_insert_enable),
    .overhead_bit_clock(overhead_bit_clock),
    .overhead_frame_marker(overhead_frame_marker),
    .overhead_slot_enable(overhead_slot_enable),
    .oh_bit_valid(oh_bit_valid), .oh_bit_value(oh_bit_value),
    .oh_bit_index(oh_bit_index), .oh_bit_inserted(oh_bit_inserted)
  );

  dto_terminal_model term (
    .clk(clk), .overhead_bit_clock(overhead_bit_clock),
    .overhead_frame_marker(overhead_frame_marker),
    .ins_mask(INS_MASK), .ins_value(INS_VALUE),
    .overhead_insert_enable(overhead_insert_enable),
    .overhead_serial_in(overhead_serial_in)
  );

  // System clock.
  always #5 clk = ~clk;

  // Line clock, offset so its edges never meet a system clock edge.
  initial
  begin
    #2;
    forever #80 transmit_input_clock = ~transmit_input_clock;
  end

  task automatic check1(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s at index %0d", $time, m, oh_bit_index);
    end
  endtask

  // Waits for the result pulse of one overhead index, with a bound.
  task automatic wait_index(input logic [5:0] idx);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (!(oh_bit_valid === 1'h1 && oh_bit_index === idx) && k < 80000);
    if (k >= 80000)
      check1(1'h0, 1'h1, "bit missing");
  endtask

  task automatic print_verdict;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence: reset, link buffer fill, two frames of rows, method 2.
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    @(posedge clk);
    #1;
    check1(oh_bit_valid, 1'h0, "valid after reset");
    check1(lapd_ready, 1'h1, "buffer not empty");
    @(negedge clk);
    lapd_valid = 1'h1;
    lapd_data = 1'h1;
    @(negedge clk);
    lapd_data = 1'h0;
    repeat (2) @(negedge clk);
    check1(lapd_ready, 1'h0, "full buffer ready");
    lapd_valid = 1'h0;
    for (int i = 0; i < 25; i++)
    begin
      {mask_fsync, mask_parity} = rows[i][3:2];
      // The inside X value changes with the frame to show it is used.
      alarm_x_bit = ~rows[i][3];
      wait_index(rows[i][9:4]);
      check1(oh_bit_value, rows[i][1], "value");
      check1(oh_bit_inserted, rows[i][0], "source");
      if (rows[i][9:4] == 6'h26)
        check1(lapd_ready, 1'h1, "buffer not drained");
      @(negedge clk);
    end
    method_select = 1'h1;
    repeat (3000)
    begin
      @(posedge clk);
      #1;
      if (overhead_slot_enable === 1'h1)
        hits++;
      if (overhead_bit_clock !== 1'h0)
        stray++;
    end
    check1(hits > 0, 1'h1, "no slot enable");
    check1(stray == 0, 1'h1, "bit clock in slot mode");
    // A mid-run reset must drop the port value stored for bit 0.
    @(negedge clk);
    rst_n = 1'h0;
    method_select = 1'h0;
    alarm_x_bit = 1'h1;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    @(posedge clk);
    #1;
    check1(oh_bit_valid, 1'h0, "valid after second reset");
    wait_index(6'h00);
    check1(oh_bit_inserted, 1'h0, "stale insert");
    check1(oh_bit_value, 1'h1, "X after reset");
    print_verdict;
  end

  // Watchdog: the rows, slot phase and second reset end near 1.09 ms.
  initial
  begin
    #1_200_000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict;
  end
endmodule
